// ===== inc/tape_fmt_pkg.sv
// Constants and carriers for the tape record formatter.
// Assumes one system clock; framing counts are in tape character slots.
package tape_fmt_pkg;
  // ****************************************
  // Framing counts
  // ****************************************
  localparam int unsigned MIN_RECORD_CHARS = 12;
  localparam int unsigned CHECK_SPACING    = 4;
  localparam int unsigned MARK_BLANKS      = 7;
  localparam int unsigned PHASE_ZEROS      = 40;
  localparam logic [7:0]  FILE_MARK_CHAR   = 8'h13;
  localparam logic [8:0]  ALL_ONES_CHAR    = 9'h1_FF;
  localparam logic [8:0]  PHASE_MARK_BITS  = 9'h0_23;
  localparam logic [8:0]  PHASE_MARK_ERASE = 9'h0_58;
  localparam int unsigned PARITY_TRACK     = 8;
  // Gap and burst lengths in thousandths of an inch; densities in characters per inch
  localparam int unsigned GAP_MILS         = 650;
  localparam int unsigned LONG_GAP_MILS    = 3000;
  localparam int unsigned BURST_MILS       = 1700;
  localparam int unsigned LOW_DENSITY      = 800;
  localparam int unsigned HIGH_DENSITY     = 1600;
  // Motion settling
  localparam int unsigned MOTION_MS        = 5;
  localparam int unsigned CLK_MHZ          = 50;
  localparam int unsigned MOTION_CYCLES    = MOTION_MS * 1000 * CLK_MHZ;
  // Format select codes
  localparam logic [3:0]  FMT_NORMAL       = 4'hC;
  localparam logic [3:0]  FMT_CORE_DUMP    = 4'hD;
  localparam logic [3:0]  FMT_REVERSED     = 4'hE;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } char_s;

  typedef struct packed {
    logic [8:0] level;
    logic [8:0] erase;
    logic       strobe;
  } track_s;
endpackage

// ===== hdl/tape_record_formatter.sv
// Tape record formatter: frames controller characters onto nine tracks.
// Assumes the transport takes one character per slot strobe.
`timescale 1ns/1ns
module tape_record_formatter #(
  parameter int unsigned SLOT_DIV      = 16,
  parameter int unsigned MOTION_CYCLES = tape_fmt_pkg::MOTION_CYCLES
) (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic        HIGH_DENSITY,
  input  wire logic [3:0]  FORMAT_SELECT,
  input  wire logic        WRITE_MARK,
  input  wire logic        AT_START,
  input  wire tape_fmt_pkg::char_s CHAR_IN,
  output logic             CHAR_READY,
  input  wire logic [15:0] MEM_WORD,
  output logic [17:0]      CTRL_WORD,
  output tape_fmt_pkg::track_s TRACK_OUT,
  output logic             PHASE_HALF,
  output logic             MOTION,
  output logic             BUSY,
  input  wire logic [8:0]  READ_CHAR,
  input  wire logic        READ_STROBE,
  output logic             READ_SYNC,
  output logic             READ_DATA_VALID,
  output logic [8:0]       READ_DATA
);
  // ****************************************
  // Sequencer
  // ****************************************
  typedef enum logic [9:0] {
    IDLE    = 10'b00_0000_0001,
    SPINUP  = 10'b00_0000_0010,
    BURST   = 10'b00_0000_0100,
    GAP     = 10'b00_0000_1000,
    PREAMB  = 10'b00_0001_0000,
    DATA    = 10'b00_0010_0000,
    PAD     = 10'b00_0100_0000,
    CHECKS  = 10'b00_1000_0000,
    POSTAMB = 10'b01_0000_0000,
    MARK    = 10'b10_0000_0000
  } state_e;

  localparam int unsigned SLOT_W = 16;
  // Slots covering a length in thousandths of an inch at density, rounded up
  function automatic logic [SLOT_W-1:0] gap_slots(input int unsigned mils,
                                                  input logic hi);
    int unsigned d;
    d = hi ? tape_fmt_pkg::HIGH_DENSITY : tape_fmt_pkg::LOW_DENSITY;
    return SLOT_W'((mils * d + 999) / 1000);
  endfunction

  state_e state;
  logic [SLOT_W-1:0] count;
  logic [$clog2(SLOT_DIV)-1:0] div;
  logic slot;
  logic first_done;
  logic mark_req;
  logic [8:0] lpar;
  logic [8:0] crc;
  logic [8:0] level;
  logic [8:0] next_char;
  logic [8:0] next_erase;
  logic [31:0] settle;

  assign slot = (div == '0);
  assign CHAR_READY = (state == DATA) && slot;
  assign BUSY = (state != IDLE);

  always_ff @(posedge CLK) begin
    if (RESET || div == ($clog2(SLOT_DIV))'(SLOT_DIV - 1)) begin
      div <= '0;
    end else begin
      div <= div + 1'b1;
    end
  end

  function automatic logic [8:0] with_parity(input logic [7:0] d);
    return {~^d, d};
  endfunction

  always_ff @(posedge CLK) begin
    if (RESET) begin
      state      <= IDLE;
      count      <= '0;
      first_done <= 1'b0;
      mark_req   <= 1'b0;
      settle     <= '0;
    end else begin
      if (state == IDLE || state == SPINUP) begin
        settle <= (state == SPINUP) ? settle + 1 : '0;
      end
      if (slot || state == IDLE || state == SPINUP) begin
        unique case (state)
          IDLE: begin
            if (CHAR_IN.valid || WRITE_MARK) begin
              mark_req <= WRITE_MARK;
              state    <= SPINUP;
            end
          end
          SPINUP: begin
            if (settle >= MOTION_CYCLES - 1) begin
              if (AT_START && !first_done && HIGH_DENSITY) begin
                state <= BURST;
                count <= gap_slots(tape_fmt_pkg::BURST_MILS, 1'b1);
              end else begin
                state <= GAP;
                count <= (!first_done || mark_req)
                  ? gap_slots(tape_fmt_pkg::LONG_GAP_MILS, HIGH_DENSITY)
                  : gap_slots(tape_fmt_pkg::GAP_MILS, HIGH_DENSITY);
              end
            end
          end
          BURST: begin
            count <= count - 1'b1;
            if (count == 1) begin
              state <= GAP;
              count <= gap_slots(tape_fmt_pkg::LONG_GAP_MILS, 1'b1);
            end
          end
          GAP: begin
            count <= count - 1'b1;
            if (count == 1) begin
              first_done <= 1'b1;
              count      <= '0;
              if (mark_req) begin
                state <= MARK;
              end else if (HIGH_DENSITY) begin
                state <= PREAMB;
              end else begin
                state <= DATA;
              end
            end
          end
          PREAMB: begin
            count <= count + 1'b1;
            if (count == SLOT_W'(tape_fmt_pkg::PHASE_ZEROS)) begin
              state <= DATA;
              count <= '0;
            end
          end
          DATA: begin
            if (CHAR_IN.valid) begin
              count <= count + 1'b1;
              if (CHAR_IN.last) begin
                if (!HIGH_DENSITY && count <
                    SLOT_W'(tape_fmt_pkg::MIN_RECORD_CHARS - 1)) begin
                  state <= PAD;
                end else begin
                  state <= HIGH_DENSITY ? POSTAMB : CHECKS;
                  count <= '0;
                end
              end
            end
          end
          PAD: begin
            count <= count + 1'b1;
            if (count == SLOT_W'(tape_fmt_pkg::MIN_RECORD_CHARS - 1)) begin
              state <= CHECKS;
              count <= '0;
            end
          end
          CHECKS: begin
            count <= count + 1'b1;
            if (count == SLOT_W'(2 * tape_fmt_pkg::CHECK_SPACING - 1)) begin
              state <= IDLE;
            end
          end
          POSTAMB: begin
            count <= count + 1'b1;
            if (count == SLOT_W'(tape_fmt_pkg::PHASE_ZEROS)) begin
              state <= IDLE;
            end
          end
          MARK: begin
            count <= count + 1'b1;
            if ((HIGH_DENSITY && count ==
                 SLOT_W'(tape_fmt_pkg::PHASE_ZEROS - 1)) ||
                (!HIGH_DENSITY && count ==
                 SLOT_W'(tape_fmt_pkg::MARK_BLANKS + 1))) begin
              state <= IDLE;
            end
          end
          default: state <= IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // Character selection
  // ****************************************
  // Pad characters are zero: they change no track and leave lpar alone, though crc still shifts.
  always_comb begin
    next_char  = '0;
    next_erase = '0;
    unique case (state)
      BURST: begin
        next_erase = ~(9'h1_00);
        next_char  = {count[0], 8'h00};
      end
      IDLE, SPINUP, GAP: next_erase = '1;
      PREAMB: begin
        if (count == SLOT_W'(tape_fmt_pkg::PHASE_ZEROS)) begin
          next_char = tape_fmt_pkg::ALL_ONES_CHAR;
        end
      end
      DATA: begin
        if (CHAR_IN.valid) begin
          next_char = with_parity(CHAR_IN.data);
        end
      end
      PAD: next_char = '0;
      CHECKS: begin
        if (count == SLOT_W'(tape_fmt_pkg::CHECK_SPACING - 1)) begin
          next_char = crc;
        end else if (count ==
                     SLOT_W'(2 * tape_fmt_pkg::CHECK_SPACING - 1)) begin
          next_char = lpar;
        end
      end
      POSTAMB: begin
        if (count == '0) begin
          next_char = tape_fmt_pkg::ALL_ONES_CHAR;
        end
      end
      MARK: begin
        if (HIGH_DENSITY) begin
          next_erase = ~tape_fmt_pkg::PHASE_MARK_BITS;
        end else if (count == '0 || count ==
                     SLOT_W'(tape_fmt_pkg::MARK_BLANKS + 1)) begin
          next_char = with_parity(tape_fmt_pkg::FILE_MARK_CHAR);
        end
      end
      default: next_char = '0;
    endcase
  end

  // ****************************************
  // Checks and track drive
  // ****************************************
  always_ff @(posedge CLK) begin
    if (RESET || state == IDLE) begin
      lpar <= '0;
      crc  <= '0;
    end else if (slot && (state == DATA || state == PAD)) begin
      lpar <= lpar ^ next_char;
      // Simple shift-feedback check; no recovery uses it
      crc  <= {crc[7:0], crc[8]} ^ next_char ^ (crc[8] ? 9'h0_3C : '0);
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      level     <= '0;
      TRACK_OUT <= '0;
    end else if (slot) begin
      TRACK_OUT.erase  <= next_erase;
      // Erased slots strobe too, so the transport can pace gaps
      TRACK_OUT.strobe <= 1'b1;
      if (HIGH_DENSITY) begin
        TRACK_OUT.level <= next_char;
      end else begin
        level           <= level ^ next_char;
        TRACK_OUT.level <= level ^ next_char;
      end
    end else begin
      TRACK_OUT.strobe <= 1'b0;
    end
  end

  // Second half of a phase cell carries the inverse
  always_ff @(posedge CLK) begin
    if (RESET) begin
      PHASE_HALF <= 1'b0;
    end else begin
      PHASE_HALF <= HIGH_DENSITY && (div >= ($clog2(SLOT_DIV))'(SLOT_DIV/2));
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      MOTION <= 1'b0;
    end else begin
      MOTION <= (state != IDLE);
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      CTRL_WORD <= '0;
    end else if (FORMAT_SELECT == tape_fmt_pkg::FMT_REVERSED) begin
      for (int i = 0; i < 16; i++) begin
        CTRL_WORD[i] <= MEM_WORD[15-i];
      end
      CTRL_WORD[16] <= 1'b0;
      CTRL_WORD[17] <= MEM_WORD[0];
    end else begin
      CTRL_WORD <= {2'b00, MEM_WORD};
    end
  end

  // ****************************************
  // Phase read alignment
  // ****************************************
  logic [5:0] zero_run;
  logic       in_data;
  always_ff @(posedge CLK) begin
    if (RESET) begin
      zero_run        <= '0;
      in_data         <= 1'b0;
      READ_SYNC       <= 1'b0;
      READ_DATA_VALID <= 1'b0;
      READ_DATA       <= '0;
    end else begin
      READ_DATA_VALID <= 1'b0;
      if (READ_STROBE) begin
        if (READ_CHAR == '0 && !in_data) begin
          zero_run <= (zero_run == '1) ? zero_run : zero_run + 1'b1;
          READ_SYNC <= (zero_run >= 6'(tape_fmt_pkg::PHASE_ZEROS / 2));
        end else if (READ_CHAR == tape_fmt_pkg::ALL_ONES_CHAR) begin
          in_data  <= READ_SYNC && !in_data;
          zero_run <= '0;
        end else if (in_data) begin
          READ_DATA_VALID <= 1'b1;
          READ_DATA       <= READ_CHAR;
        end else begin
          zero_run  <= '0;
          READ_SYNC <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  motion_a: assert property (@(posedge CLK) disable iff (RESET)
    (state == SPINUP && $past(state) == IDLE) |=> MOTION[*3])
    else $error("motion dropped during spin-up");
  reverse_a: assert property (@(posedge CLK) disable iff (RESET)
    FORMAT_SELECT == tape_fmt_pkg::FMT_REVERSED ##1 1'b1 |->
    CTRL_WORD[0] == $past(MEM_WORD[15]))
    else $error("reversed mapping wrong");
  lpar_a: assert property (@(posedge CLK) disable iff (RESET)
    (state == CHECKS && slot && count == 7) |=> TRACK_OUT.strobe)
    else $error("longitudinal char not strobed");

  sequence gap_slot_s;
    state == GAP && slot;
  endsequence
  sequence erased_out_s;
    TRACK_OUT.erase == '1 && TRACK_OUT.strobe;
  endsequence
  gap_erase_a: assert property (@(posedge CLK) disable iff (RESET)
    gap_slot_s |=> erased_out_s)
    else $error("record gap not erased");
  preamble_ones_a: assert property (@(posedge CLK) disable iff (RESET)
    (state == PREAMB && slot &&
     count == SLOT_W'(tape_fmt_pkg::PHASE_ZEROS)) |=>
    TRACK_OUT.level == tape_fmt_pkg::ALL_ONES_CHAR)
    else $error("preamble ones char missing");
  mark_erase_a: assert property (@(posedge CLK) disable iff (RESET)
    (state == MARK && slot && HIGH_DENSITY) |=>
    TRACK_OUT.erase == ~tape_fmt_pkg::PHASE_MARK_BITS)
    else $error("phase file mark tracks wrong");
endmodule

// ===== verification/tape_transport_model.sv
// Transport model: decodes track slots and plays read characters.
// Assumes one strobe per character slot from the formatter.
`timescale 1ns/1ns
module tape_transport_model (
  input  wire logic                 clk,
  input  wire logic                 hd,
  input  wire logic                 half,
  input  wire tape_fmt_pkg::track_s trk,
  output logic [8:0]                rd_char,
  output logic                      rd_stb
);
  // ****************
  // Slot capture
  // ****************
  logic [8:0] cap[$];
  logic [8:0] prev = '0;
  logic [8:0] lv1 = '0;
  logic       half1 = 1'b0;
  int         gap = 0;
  int         last_gap = 0;
  int         burst = 0;
  int         mark = 0;
  int         bad = 0;
  initial begin
    rd_char = 9'h0_00;
    rd_stb = 1'b0;
  end
  always @(posedge clk) begin
    lv1 <= trk.level;
    half1 <= half;
    // cell inverts mid slot
    // Level holds through the cell; the half flag inverts the line
    if (hd && half && !half1 && ((trk.level ^ lv1) & ~trk.erase) != 0) begin
      bad <= bad + 1;
    end
    if (trk.strobe === 1'b1) begin
      prev <= trk.level;
      if (trk.erase === 9'h1_FF) begin
        gap <= gap + 1;
      end else begin
        if (gap != 0) last_gap <= gap;
        gap <= 0;
        cap.push_back(hd ? trk.level : trk.level ^ prev);
      end
      if (trk.erase === 9'h0_FF) burst <= burst + 1;
      if ((trk.erase & 9'h0_58) == 9'h0_58 && (trk.erase & 9'h0_23) == 0
          && (trk.level & 9'h0_23) == 0) mark <= mark + 1;
    end
  end
  // Released read line shows the inverse, never a stale copy
  task automatic send(input logic [8:0] c);
    @(negedge clk);
    rd_char = c;
    rd_stb = 1'b1;
    @(negedge clk);
    rd_stb = 1'b0;
    rd_char = ~c;
  endtask
endmodule

// ===== verification/test_tape_record_formatter.sv
// Testbench for the tape record formatter.
// Assumes the transport model on the track and read ports.
`timescale 1ns/1ns
`define M u_tape_transport_model
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  miscompares++; $display("[FAIL] %0t mismatch", $time); end end
module test_tape_record_formatter;
  // ****************
  // Bench
  // ****************
  logic                 clk = 1'b0;
  logic                 reset = 1'b1;
  logic                 hd = 1'b0;
  logic [3:0]           fmt = 4'hC;
  logic                 wmark = 1'b0;
  logic                 at_start = 1'b0;
  tape_fmt_pkg::char_s  cin = '0;
  logic                 ready;
  logic [15:0]          mem = '0;
  logic [17:0]          word;
  tape_fmt_pkg::track_s trk;
  logic                 half;
  logic                 motion;
  logic                 busy;
  logic [8:0]           rd_char;
  logic                 rd_stb;
  logic                 sync;
  logic                 rd_valid;
  logic [8:0]           rd_data;
  logic [8:0]           rq[$];
  int                   miscompares = 0;
  int                   comparisons = 0;
  // Short counts keep the run brief
  tape_record_formatter #(.SLOT_DIV(4), .MOTION_CYCLES(4)) u_tape_record_formatter (
    .CLK(clk), .RESET(reset), .HIGH_DENSITY(hd), .FORMAT_SELECT(fmt),
    .WRITE_MARK(wmark), .AT_START(at_start), .CHAR_IN(cin),
    .CHAR_READY(ready), .MEM_WORD(mem), .CTRL_WORD(word),
    .TRACK_OUT(trk), .PHASE_HALF(half), .MOTION(motion), .BUSY(busy),
    .READ_CHAR(rd_char), .READ_STROBE(rd_stb), .READ_SYNC(sync),
    .READ_DATA_VALID(rd_valid), .READ_DATA(rd_data));
  tape_transport_model u_tape_transport_model (.clk(clk), .hd(hd),
    .half(half), .trk(trk), .rd_char(rd_char), .rd_stb(rd_stb));
  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rd_valid === 1'b1) rq.push_back(rd_data);
  end
  function automatic logic [7:0] dat(input int i);
    return 8'hA5 ^ 8'(i * 37);
  endfunction
  task automatic idle_wait();
    int k;
    for (k = 0; k < 40000 && busy !== 1'b0; k++) @(negedge clk);
    for (k = 0; k < 20 && motion !== 1'b0; k++) @(negedge clk);
    `CHK(motion, 1'b0)
    repeat (3) @(negedge clk);
  endtask
  task automatic put(input logic [7:0] d, input logic l);
    int k;
    @(negedge clk);
    cin = '{1'b1, l, d};
    #2;
    for (k = 0; k < 40000 && ready !== 1'b1; k++) @(negedge clk) #2;
    @(posedge clk);
    if (l) begin
      @(negedge clk);
      cin = '0;
    end
  endtask
  task automatic rec(input logic h, input int n);
    int i;
    hd = h;
    `M.cap.delete();
    for (i = 0; i < n; i++) put(dat(i), i == n - 1);
    idle_wait();
  endtask
  task automatic chk_nrzi(input int n);
    int i;
    logic [7:0] x;
    x = '0;
    `CHK(`M.cap.size(), 20)
    for (i = 0; i < 20; i++) begin
      if (i != 15) x ^= `M.cap[i][7:0];
      if (i < n) `CHK(`M.cap[i][7:0], dat(i))
      else if (i != 15 && i != 19) `CHK(`M.cap[i][7:0], 8'h00)
    end
    `CHK(`M.cap[15] != 9'h0_00, 1'b1)
    `CHK(x, 8'h00)
    `CHK(^`M.cap[0], ^`M.cap[1])
  endtask
  task automatic t_start();
    int b0;
    at_start = 1'b1;
    b0 = `M.burst;
    rec(1'b1, 1);
    `CHK(`M.burst - b0 >= 2720, 1'b1)
    `CHK(`M.last_gap >= 4800, 1'b1)
    at_start = 1'b0;
    $display("start test done");
  endtask
  task automatic t_nrzi();
    int k;
    @(negedge clk);
    hd = 1'b0;
    cin = '{1'b1, 1'b0, dat(0)};
    for (k = 0; k < 20 && motion !== 1'b1; k++) @(negedge clk);
    `CHK(k <= 6, 1'b1)
    rec(1'b0, 12);
    chk_nrzi(12);
    rec(1'b0, 3);
    chk_nrzi(3);
    `CHK(`M.last_gap >= 400, 1'b1)
    $display("low density test done");
  endtask
  task automatic t_mark(input logic h);
    int k;
    int m0;
    hd = h;
    m0 = `M.mark;
    `M.cap.delete();
    @(negedge clk);
    wmark = 1'b1;
    for (k = 0; k < 10 && busy !== 1'b1; k++) @(negedge clk);
    wmark = 1'b0;
    idle_wait();
    `CHK(`M.last_gap >= (h ? 4800 : 2400), 1'b1)
    if (h) `CHK(`M.mark - m0, 40)
    else begin
      `CHK(`M.cap.size(), 9)
      for (k = 0; k < 9; k++)
        `CHK(`M.cap[k][7:0], (k % 8 == 0) ? 8'h13 : 8'h00)
    end
    $display("file mark test done");
  endtask
  task automatic t_pe();
    int i;
    rec(1'b1, 2);
    `CHK(`M.cap.size(), 84)
    for (i = 0; i < 84; i++)
      if (i == 41 || i == 42) `CHK(`M.cap[i][7:0], dat(i - 41))
      else `CHK(`M.cap[i], (i == 40 || i == 43) ? 9'h1_FF : 9'h0_00)
    `CHK(`M.bad, 0)
    `CHK(`M.last_gap >= 800, 1'b1)
    $display("phase test done");
  endtask
  task automatic t_words();
    fmt = tape_fmt_pkg::FMT_REVERSED;
    mem = 16'h8000;
    @(negedge clk);
    `CHK(word[0], 1'b1)
    mem = 16'h0001;
    @(negedge clk);
    `CHK({word[17], word[0]}, 2'b10)
    fmt = tape_fmt_pkg::FMT_CORE_DUMP;
    @(negedge clk);
    fmt = tape_fmt_pkg::FMT_NORMAL;
    @(negedge clk);
    `CHK(word[0], 1'b1)
    $display("word test done");
  endtask
  task automatic t_read();
    int i;
    hd = 1'b1;
    rq.delete();
    for (i = 0; i < 25; i++) `M.send(9'h0_00);
    `CHK(sync, 1'b1)
    `M.send(9'h1_FF);
    `M.send(9'h1_A5);
    `M.send(9'h0_3C);
    `M.send(9'h1_FF);
    for (i = 0; i < 4; i++) `M.send(9'h0_00);
    `CHK(rq.size() >= 2, 1'b1)
    `CHK({rq[0][7:0], rq[1][7:0]}, 16'hA53C)
    $display("read test done");
  endtask
  task automatic finish_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge clk);
    reset = 1'b0;
    t_start();
    t_nrzi();
    t_mark(1'b0);
    t_pe();
    t_mark(1'b1);
    t_words();
    t_read();
    finish_test();
  end
  // Whole run is near 68k cycles
  initial begin
    #1_900_000;
    miscompares++;
    finish_test();
  end
endmodule
